//--- hw/rcr_map.vh
// constants of the regulator control register bank: command codes, fields, resets, timing
// assumes inclusion by the bank modules only; definitions only
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

`define RCR_CMD_SLEW 8'hda
`define RCR_CMD_LOWPWR 8'he5
`define RCR_CMD_CTRL 8'hea

`define RCR_SLEW_MSB 3
`define RCR_SLEW_LSB 0
`define RCR_SLEW_RST 4'h4
`define RCR_LP_DIRECT_BIT 0
`define RCR_LP_PIN_BIT 1
`define RCR_LP_RST 2'h0
`define RCR_LP_PIN_RST 1'h0
`define RCR_LP_DIRECT_RST 1'h0
`define RCR_CTRL_SINK_BIT 9
`define RCR_CTRL_PHASE_BIT 3
`define RCR_CTRL_SINK_RST 1'h0
`define RCR_CTRL_PHASE_RST 1'h0
`define RCR_CTRL_RSVD_VAL 16'h0000

`define RCR_CLK_PS 5000
`define RCR_STEP_BASE_PS 20000000
`define RCR_STEP_LSB_PS 2500000
// step figures above divided by the clock period, sized for the 14-bit counter
`define RCR_STEP_BASE_CYC 14'h0fa0
`define RCR_STEP_LSB_CYC 14'h01f4

`endif

//--- hw/rcr_sync2.v
// two-stage synchroniser for one level from outside the clock domain
// assumes clk is the bank clock and arst_n its asynchronous reset
`timescale 1ns/1ps
module rcr_sync2 #(
  parameter RST_VAL = 1'b1
) (
  input wire clk,
  input wire arst_n,
  input wire d_async,
  output reg q
);
  reg stage1;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      stage1 <= d_async;
      q <= stage1;
    end
  end
endmodule

//--- hw/rcr_regs.v
// configuration register bank of a multi-phase step-down regulator: slew step,
// phase shedding and function control, reached by decoded management-bus commands
// assumes a command engine presents one-cycle read and write strobes on clk
//
// What this block does
// - slew step paces output transitions only after soft start has finished.
// - step period is 20us per 2mV plus 2.5us per LSB; default code 4.
// - low-power register switches follower phases on or off.
// - pin-controlled bit at zero ignores the pin; the direct bit alone sets low power.
// - pin-controlled bit at one: low power while the pin is low.
// - direct bit zero disables unless the pin path requests it; one enables low-power mode.
// - leading phase is never disabled; low power sheds followers only.
// - control bit 9 zero enables output sinking, one disables it.
// - control bit 3 selects single-phase (0) or multi-phase (1) operation.
// - ramp amplitude derives from phase bit and compensation ramp field.
// - only control bits 9 and 3 are writable; others read-only.
`timescale 1ns/1ps
`include "rcr_map.vh"
module rcr_regs #(
  parameter [13:0] STEP_BASE_CYC = `RCR_STEP_BASE_CYC,
  parameter [13:0] STEP_LSB_CYC = `RCR_STEP_LSB_CYC
) (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [7:0] wr_cmd,
  input wire [15:0] wr_data,
  input wire rd_en,
  input wire [7:0] rd_cmd,
  output reg [15:0] rd_data,
  output reg rd_valid,
  output reg rd_unsupported,
  input wire power_state_pin_n,
  input wire soft_start_done,
  input wire vout_change_pending,
  input wire [2:0] comp_ramp_field,
  output reg slew_step_field_tick,
  output reg [3:0] slew_step_field,
  output reg low_power_active,
  output reg leading_phase_en,
  output reg follower_phase_en,
  output reg output_sinking_mode,
  output reg multi_phase,
  output reg [3:0] ramp_select
);
  reg pin_controlled_low_power;
  reg direct_low_power_bit;
  reg ctrl_sink_bit;
  reg ctrl_phase_bit;
  reg [13:0] step_count;
  reg [13:0] next_step_count;
  reg next_step_tick;
  reg [15:0] next_rd_data;
  reg next_rd_unsupported;
  reg next_follower_phase_en;
  reg next_output_sinking_mode;
  reg [3:0] next_ramp_select;
  reg next_low_power;
  wire ps_sync_n;
  wire [13:0] step_period;

  // cycles per 2 mV step for a given code; max 11500 fits 14 bits
  function [13:0] rcr_step_cycles;
    input [3:0] code;
    begin
      rcr_step_cycles = STEP_BASE_CYC + STEP_LSB_CYC * {10'h000, code};
    end
  endfunction

  // true only for the three codes this bank owns; anything else reads as zero
  function rcr_cmd_known;
    input [7:0] cmd;
    begin
      case (cmd)
        `RCR_CMD_SLEW: rcr_cmd_known = 1'b1;
        `RCR_CMD_LOWPWR: rcr_cmd_known = 1'b1;
        `RCR_CMD_CTRL: rcr_cmd_known = 1'b1;
        default: rcr_cmd_known = 1'b0;
      endcase
    end
  endfunction

  // read image of each register; reserved positions show their defaults
  function [15:0] rcr_read_value;
    input [7:0] cmd;
    begin
      case (cmd)
        `RCR_CMD_SLEW: rcr_read_value = {12'h000, slew_step_field};
        `RCR_CMD_LOWPWR: rcr_read_value = {14'h0000, pin_controlled_low_power,
                                           direct_low_power_bit};
        `RCR_CMD_CTRL: begin
          rcr_read_value = `RCR_CTRL_RSVD_VAL;
          rcr_read_value[`RCR_CTRL_SINK_BIT] = ctrl_sink_bit;
          rcr_read_value[`RCR_CTRL_PHASE_BIT] = ctrl_phase_bit;
        end
        default: rcr_read_value = 16'h0000;
      endcase
    end
  endfunction

  // pin resets high so a release of reset never looks like a low-power request
  rcr_sync2 #(
    .RST_VAL(1'b1)
  ) u_ps_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d_async(power_state_pin_n),
    .q(ps_sync_n)
  );

  // slew register; the reserved upper nibble is never stored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slew_step_field <= `RCR_SLEW_RST;
    end else if (wr_en && (wr_cmd == `RCR_CMD_SLEW)) begin
      slew_step_field <= wr_data[`RCR_SLEW_MSB:`RCR_SLEW_LSB];
    end
  end

  // low-power register; bits 7..2 are reserved and dropped
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_controlled_low_power <= `RCR_LP_PIN_RST;
      direct_low_power_bit <= `RCR_LP_DIRECT_RST;
    end else if (wr_en && (wr_cmd == `RCR_CMD_LOWPWR)) begin
      pin_controlled_low_power <= wr_data[`RCR_LP_PIN_BIT];
      direct_low_power_bit <= wr_data[`RCR_LP_DIRECT_BIT];
    end
  end

  // control register; only the sink and phase bits exist as storage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_sink_bit <= `RCR_CTRL_SINK_RST;
      ctrl_phase_bit <= `RCR_CTRL_PHASE_RST;
    end else if (wr_en && (wr_cmd == `RCR_CMD_CTRL)) begin
      ctrl_sink_bit <= wr_data[`RCR_CTRL_SINK_BIT];
      ctrl_phase_bit <= wr_data[`RCR_CTRL_PHASE_BIT];
    end
  end

  // reads answer one cycle after the strobe; rd_data holds until the next read
  always @* begin
    next_rd_data = rd_data;
    next_rd_unsupported = 1'b0;
    if (rd_en) begin
      next_rd_data = rcr_read_value(rd_cmd);
      next_rd_unsupported = !rcr_cmd_known(rd_cmd);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_unsupported <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_unsupported <= next_rd_unsupported;
      rd_data <= next_rd_data;
    end
  end

  // direct bit or pin path; pin path is dead while its enable bit is clear
  always @* begin
    next_low_power = direct_low_power_bit;
    if (pin_controlled_low_power && !ps_sync_n) begin
      next_low_power = 1'b1;
    end
  end

  // derived controls follow the registers one cycle later
  always @* begin
    // followers exist only in a multi-phase arrangement
    next_follower_phase_en = ctrl_phase_bit & ~next_low_power;
    next_output_sinking_mode = ~ctrl_sink_bit;
    next_ramp_select = {ctrl_phase_bit, comp_ramp_field};
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_power_active <= 1'b0;
      leading_phase_en <= 1'b1;
      follower_phase_en <= 1'b0;
      output_sinking_mode <= 1'b1;
      multi_phase <= 1'b0;
      ramp_select <= 4'h0;
    end else begin
      low_power_active <= next_low_power;
      leading_phase_en <= 1'b1;
      follower_phase_en <= next_follower_phase_en;
      output_sinking_mode <= next_output_sinking_mode;
      multi_phase <= ctrl_phase_bit;
      ramp_select <= next_ramp_select;
    end
  end

  // step pacing; held idle during soft start so its own ramp is untouched
  assign step_period = rcr_step_cycles(slew_step_field);

  // dropping either condition restarts the count, so a resumed move waits a full period
  always @* begin
    next_step_count = step_count + 14'h0001;
    next_step_tick = 1'b0;
    if (!soft_start_done || !vout_change_pending) begin
      next_step_count = 14'h0000;
    end else if (step_count >= step_period - 14'h0001) begin
      next_step_count = 14'h0000;
      next_step_tick = 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_count <= 14'h0000;
      slew_step_field_tick <= 1'b0;
    end else begin
      step_count <= next_step_count;
      slew_step_field_tick <= next_step_tick;
    end
  end
endmodule

//--- dv/rcr_regs_assertions.sv
// checker of the regulator register bank outputs
// assumes it is bound onto rcr_regs and sees only its ports
`timescale 1ns/1ps
module rcr_chk (
  input wire clk,
  input wire arst_n,
  input wire rd_en,
  input wire rd_valid,
  input wire wr_en,
  input wire [7:0] wr_cmd,
  input wire [15:0] wr_data,
  input wire soft_start_done,
  input wire slew_step_field_tick,
  input wire low_power_active,
  input wire leading_phase_en,
  input wire follower_phase_en,
  input wire output_sinking_mode,
  input wire multi_phase,
  input wire [3:0] ramp_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RDV: assert property (rd_valid == $past(rd_en))
    else $error("read answer not one cycle after request");
  AST_LEAD: assert property (leading_phase_en)
    else $error("leading phase dropped");
  AST_SS: assert property (slew_step_field_tick |-> $past(soft_start_done))
    else $error("step tick during soft start");
  AST_TICK: assert property (slew_step_field_tick |=> !slew_step_field_tick)
    else $error("step ticks too close");
  AST_FOL: assert property (follower_phase_en |-> multi_phase && !low_power_active)
    else $error("follower on in low power or single phase");
  AST_RAMP: assert property (ramp_select[3] == multi_phase)
    else $error("ramp select ignores phase bit");
  AST_SINK: assert property (wr_en && wr_cmd == 8'hea && wr_data[9]
    |-> ##[1:2] !output_sinking_mode)
    else $error("sinking not disabled");
  AST_LP: assert property (wr_en && wr_cmd == 8'he5 && wr_data[0]
    |-> ##[1:2] low_power_active)
    else $error("direct low power not entered");
endmodule
bind rcr_regs rcr_chk u_chk (.clk, .arst_n, .rd_en, .rd_valid, .wr_en, .wr_cmd, .wr_data,
  .soft_start_done, .slew_step_field_tick, .low_power_active, .leading_phase_en,
  .follower_phase_en, .output_sinking_mode, .multi_phase, .ramp_select);

//--- dv/rcr_host.sv
// host model: issues one-cycle write and read commands
// assumes the read answer stands one cycle after the request is taken
`timescale 1ns/1ps
module rcr_host (
  input wire clk,
  input wire [15:0] rd_data,
  input wire rd_valid,
  output reg wr_en,
  output reg [7:0] wr_cmd,
  output reg [15:0] wr_data,
  output reg rd_en,
  output reg [7:0] rd_cmd
);
  initial {wr_en, wr_cmd, wr_data, rd_en, rd_cmd} = 0;
  // writes all bits as given; masking is up to the bank
  task wr(input [7:0] c, input [15:0] d);
    @(posedge clk);
    wr_en <= 1;
    wr_cmd <= c;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 0;
    wr_data <= ~d;
  endtask
  task rd(input [7:0] c, output [15:0] d, output v);
    @(posedge clk);
    rd_en <= 1;
    rd_cmd <= c;
    @(posedge clk);
    rd_en <= 0;
    #1 d = rd_data;
    v = rd_valid;
  endtask
endmodule

//--- dv/regulator_ctrl_registers_bench.sv
// self-checking bench of the regulator register bank
// assumes rcr_host drives the command port; step counts cut to 4 and 1
`timescale 1ns/1ps
module regulator_ctrl_registers_bench;
  reg clk = 0, arst_n = 0, power_state_pin_n = 1, soft_start_done = 0, vout_change_pending = 0;
  reg [2:0] comp_ramp_field = 3'h5;
  wire [15:0] rd_data, wr_data;
  wire [7:0] wr_cmd, rd_cmd;
  wire [3:0] slew_step_field, ramp_select;
  wire wr_en, rd_en, rd_valid, rd_unsupported, slew_step_field_tick, low_power_active;
  wire leading_phase_en, follower_phase_en, output_sinking_mode, multi_phase;
  reg [15:0] d;
  reg v;
  integer num_errors = 0, n_checks = 0;
  rcr_regs #(.STEP_BASE_CYC(14'h0004), .STEP_LSB_CYC(14'h0001)) i_dut (.clk, .arst_n, .wr_en,
    .wr_cmd, .wr_data, .rd_en, .rd_cmd, .rd_data, .rd_valid, .rd_unsupported,
    .power_state_pin_n, .soft_start_done, .vout_change_pending, .comp_ramp_field,
    .slew_step_field_tick, .slew_step_field, .low_power_active, .leading_phase_en,
    .follower_phase_en, .output_sinking_mode, .multi_phase, .ramp_select);
  rcr_host i_host (.clk, .rd_data, .rd_valid, .wr_en, .wr_cmd, .wr_data, .rd_en, .rd_cmd);
  initial forever #2.5 clk = ~clk;
  task chk(input [15:0] g, input [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task rdchk(input [7:0] c, input [15:0] e);
    i_host.rd(c, d, v);
    chk(v, 1);
    chk(d, e);
  endtask
  task w(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task gap(input [15:0] e);
    integer i, k, t;
    k = 0;
    t = 0;
    for (i = 0; i < 99 && k < 2; i++) begin
      w(1);
      if (slew_step_field_tick === 1'b1) begin
        k++;
        t = i - t;
      end
    end
    if (k < 2) begin
      num_errors++;
      close_out;
    end else begin
      chk(t[15:0], e);
    end
  endtask
  task t_rst;
    chk(slew_step_field, 4'h4);
    rdchk(8'hda, 16'h0004);
    rdchk(8'he5, 16'h0000);
    i_host.rd(8'h00, d, v);
    chk(rd_unsupported, 1);
    chk(d, 0);
    $display("reset done");
  endtask
  task t_regs;
    i_host.wr(8'hea, 16'hffff);
    rdchk(8'hea, 16'h0208);
    chk({output_sinking_mode, multi_phase}, 2'h1);
    chk(ramp_select, 4'hd);
    i_host.wr(8'hda, 16'hffff);
    rdchk(8'hda, 16'h000f);
    chk(slew_step_field, 4'hf);
    i_host.wr(8'he5, 16'hffff);
    rdchk(8'he5, 16'h0003);
    $display("regs done");
  endtask
  task t_lp;
    i_host.wr(8'he5, 16'h0002);
    w(3);
    chk({low_power_active, follower_phase_en}, 2'h1);
    @(posedge clk) power_state_pin_n <= 0;
    w(5);
    chk({low_power_active, follower_phase_en, leading_phase_en}, 3'h5);
    @(posedge clk) power_state_pin_n <= 1;
    w(5);
    chk({low_power_active, follower_phase_en}, 2'h1);
    @(posedge clk) power_state_pin_n <= 0;
    w(5);
    chk(low_power_active, 1);
    i_host.wr(8'he5, 16'h0000);
    w(3);
    chk(low_power_active, 0);
    @(posedge clk) power_state_pin_n <= 1;
    i_host.wr(8'he5, 16'h0001);
    w(5);
    chk(low_power_active, 1);
    i_host.wr(8'he5, 16'h0000);
    i_host.wr(8'hea, 16'h0000);
    w(2);
    chk({output_sinking_mode, multi_phase, follower_phase_en}, 3'h4);
    @(posedge clk) comp_ramp_field <= 3'h2;
    w(2);
    chk(ramp_select, 4'h2);
    $display("low power done");
  endtask
  task t_tick;
    i_host.wr(8'hda, 16'h0000);
    vout_change_pending <= 1;
    repeat (20) begin
      w(1);
      chk(slew_step_field_tick, 0);
    end
    @(posedge clk) soft_start_done <= 1;
    gap(16'h0004);
    @(posedge clk) soft_start_done <= 0;
    i_host.wr(8'hda, 16'h0004);
    soft_start_done <= 1;
    gap(16'h0008);
    $display("tick done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1;
    t_rst;
    t_regs;
    t_lp;
    t_tick;
    close_out;
  end
endmodule
